// ==== design/diag_readout_pkg.sv ====
package diag_readout_pkg;

  // frame geometry
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned BANK_CHANNELS = 8;
  localparam int unsigned CHANNELS      = 16;
  localparam logic [3:0]  BIT_CNT_RST   = 4'h0;
  localparam logic [3:0]  BIT_CNT_LAST  = 4'hF;

  // control byte codes
  localparam logic [7:0] CMD_DIAG_LO  = 8'h00;
  localparam logic [7:0] CMD_DIAG_HI  = 8'h0F;
  localparam logic [7:0] CMD_READ_LO  = 8'hC0;
  localparam logic [7:0] CMD_READ_HI  = 8'hCF;
  localparam logic [7:0] CMD_ECHO_LO  = 8'hA0;
  localparam logic [7:0] CMD_ECHO_HI  = 8'hAF;

  // two-bit channel status codes
  localparam logic [1:0] STAT_OK      = 2'h3;
  localparam logic [1:0] STAT_OVLD    = 2'h2;
  localparam logic [1:0] STAT_OPEN    = 2'h1;
  localparam logic [1:0] STAT_SHORT   = 2'h0;

  localparam logic [15:0] WORD_RST    = 16'h0000;

  // response prepared for the next frame
  typedef enum logic [3:0] {
    RSP_NONE = 4'b0001,
    RSP_DIAG = 4'b0010,
    RSP_READ = 4'b0100,
    RSP_ECHO = 4'b1000
  } rsp_e;

  // serial pins, before or after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } spi_pins_s;

  // one channel's fault state from the power stage
  typedef struct packed {
    logic ovld;
    logic open_load;
    logic short_gnd;
  } chan_fault_s;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import diag_readout_pkg::*;
(
  input  wire logic                     clk_in,   // core clock
  input  wire logic                     rst_in,   // sync reset
  input  wire logic                     ce_in,    // clock enable
  input  wire diag_readout_pkg::spi_pins_s raw_in, // asynchronous pins
  output      diag_readout_pkg::spi_pins_s sync_out // synchronised pins
);
  spi_pins_s meta_ff;
  spi_pins_s nxt_meta;
  spi_pins_s sync_ff;
  spi_pins_s nxt_sync;

  // two flops; first one feeds only the second
  always_comb
  begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (ce_in)
    begin
      nxt_meta = raw_in;
      nxt_sync = meta_ff;
    end
  end

  // chip select idles high so reset to inactive
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_ff <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
      sync_ff <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ==== design/spi_diag_readout.sv ====
`timescale 1ns/1ps
module spi_diag_readout
  import diag_readout_pkg::*;
(
  input  wire logic                        clk_in,     // 250 MHz core clock
  input  wire logic                        rst_in,     // sync reset, active high
  input  wire logic                        ce_in,      // clock enable
  input  wire logic                        cs_n_in,    // chip select pin, low active
  input  wire logic                        sclk_in,    // serial clock pin from host
  input  wire logic                        si_in,      // serial data in pin
  input  wire logic [15:0]                 par_in,     // parallel input levels, channel 1 at bit 0
  input  wire diag_readout_pkg::chan_fault_s [15:0] fault_in, // live fault state per channel
  output      logic                        so_out,     // serial data out
  output      logic                        so_oe_n_out,// so enable, low while driving
  output      logic                        outputs_hold_out // high: command changes no output
);
  ////////////////////////////////////////////////////////////////////////////////
  spi_pins_s raw;
  spi_pins_s pins;
  assign raw = '{cs_n: cs_n_in, sclk: sclk_in, si: si_in};

  pin_sync u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .raw_in   (raw),
    .sync_out (pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised pins (second stage only)
  logic cs_d_ff, sclk_d_ff;
  logic nxt_cs_d, nxt_sclk_d;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, active;

  assign cs_fall   = cs_d_ff & ~pins.cs_n;
  assign cs_rise   = ~cs_d_ff & pins.cs_n;
  assign sclk_rise = ~sclk_d_ff & pins.sclk & ~pins.cs_n;
  assign sclk_fall = sclk_d_ff & ~pins.sclk & ~pins.cs_n;
  assign active    = ~pins.cs_n;

  always_comb
  begin
    nxt_cs_d   = ce_in ? pins.cs_n : cs_d_ff;
    nxt_sclk_d = ce_in ? pins.sclk : sclk_d_ff;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cs_d_ff   <= 1'b1;
      sclk_d_ff <= 1'b0;
    end
    else
    begin
      cs_d_ff   <= nxt_cs_d;
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status helpers
  function automatic logic [1:0] stat_code(input chan_fault_s f);
    if (f.short_gnd)      stat_code = STAT_SHORT;
    else if (f.open_load) stat_code = STAT_OPEN;
    else if (f.ovld)      stat_code = STAT_OVLD;
    else                  stat_code = STAT_OK;
  endfunction

  function automatic logic any_fault(input logic [1:0] code);
    any_fault = (code != STAT_OK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // diagnosis register: latched faults, cleared per bank after read-out
  logic [1:0] diag_ff [CHANNELS];
  logic [1:0] nxt_diag [CHANNELS];
  logic       clr_lo, clr_hi;

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      nxt_diag[i] = diag_ff[i];
      if (ce_in)
      begin
        if ((i < BANK_CHANNELS) ? clr_lo : clr_hi)
          nxt_diag[i] = STAT_OK;
        // a fault present in the clear cycle wins over the clear
        if (stat_code(fault_in[i]) != STAT_OK)
          nxt_diag[i] = stat_code(fault_in[i]);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < CHANNELS; i++)
      diag_ff[i] <= rst_in ? STAT_OK : nxt_diag[i];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame engine
  logic [15:0] rx_ff, nxt_rx;
  logic [15:0] tx_ff, nxt_tx;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic        full_ff, nxt_full;
  rsp_e        rsp_ff, nxt_rsp;      // response for the current frame
  logic        hi_ff, nxt_hi;        // bank of the current response
  logic        so_ff, nxt_so;
  logic        hold_ff, nxt_hold;
  logic [7:0]  ctrl;
  logic [15:0] diag_word, read_word;

  assign ctrl = nxt_rx[15:8];

  // build candidate words for the selected bank
  always_comb
  begin
    diag_word = WORD_RST;
    read_word = WORD_RST;
    for (int k = 0; k < BANK_CHANNELS; k++)
    begin
      diag_word[2*k +: 2] = diag_ff[k + (ctrl[0] ? BANK_CHANNELS : 0)];
      read_word[8 + k]    = par_in[k + (ctrl[0] ? BANK_CHANNELS : 0)];
      read_word[k]        = ~any_fault(diag_ff[k + (ctrl[0] ? BANK_CHANNELS : 0)]);
    end
  end

  always_comb
  begin
    nxt_rx   = rx_ff;
    nxt_tx   = tx_ff;
    nxt_cnt  = cnt_ff;
    nxt_full = full_ff;
    nxt_rsp  = rsp_ff;
    nxt_hi   = hi_ff;
    nxt_so   = so_ff;
    nxt_hold = hold_ff;
    clr_lo   = 1'b0;
    clr_hi   = 1'b0;
    if (ce_in)
    begin
      if (cs_fall)
      begin
        nxt_cnt  = BIT_CNT_RST;
        nxt_full = 1'b0;
        nxt_so   = tx_ff[15];
      end
      if (sclk_rise)
      begin
        nxt_rx   = {rx_ff[14:0], pins.si};
        nxt_cnt  = cnt_ff + 4'h1;
        nxt_full = full_ff | (cnt_ff == BIT_CNT_LAST);
      end
      if (sclk_fall)
      begin
        nxt_tx = {tx_ff[14:0], 1'b0};
        nxt_so = tx_ff[14];
      end
      if (rsp_ff == RSP_ECHO && active)
        nxt_so = pins.si;
      if (cs_rise)
      begin
        nxt_rsp  = RSP_NONE;
        nxt_tx   = WORD_RST;
        nxt_hi   = ctrl[0];
        nxt_hold = 1'b0;
        // a previous echo frame triggers no processing
        if (full_ff && rsp_ff != RSP_ECHO)
        begin
          unique case (ctrl)
            CMD_DIAG_LO, CMD_DIAG_HI:
            begin
              nxt_rsp  = RSP_DIAG;
              nxt_tx   = diag_word;
              clr_lo   = ~ctrl[0];            // captured now, later faults wait
              clr_hi   = ctrl[0];
              nxt_hold = 1'b1;
            end
            CMD_READ_LO, CMD_READ_HI:
            begin
              nxt_rsp  = RSP_READ;
              nxt_tx   = read_word;
              nxt_hold = 1'b1;
            end
            CMD_ECHO_LO, CMD_ECHO_HI:
            begin
              nxt_rsp  = RSP_ECHO;
              nxt_hold = 1'b1;
            end
            default:
              nxt_hold = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_ff   <= WORD_RST;
      tx_ff   <= WORD_RST;
      cnt_ff  <= BIT_CNT_RST;
      full_ff <= 1'b0;
      rsp_ff  <= RSP_NONE;
      hi_ff   <= 1'b0;
      so_ff   <= 1'b0;
      hold_ff <= 1'b0;
    end
    else
    begin
      rx_ff   <= nxt_rx;
      tx_ff   <= nxt_tx;
      cnt_ff  <= nxt_cnt;
      full_ff <= nxt_full;
      rsp_ff  <= nxt_rsp;
      hi_ff   <= nxt_hi;
      so_ff   <= nxt_so;
      hold_ff <= nxt_hold;
    end
  end

  assign so_out           = so_ff;
  assign so_oe_n_out      = pins.cs_n;     // drive only inside a frame
  assign outputs_hold_out = hold_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_echo_armed;
    cs_rise && full_ff && rsp_ff != RSP_ECHO && (ctrl == CMD_ECHO_LO || ctrl == CMD_ECHO_HI);
  endsequence

  property p_echo_loop;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && rsp_ff == RSP_ECHO && active |=> so_ff == $past(pins.si);
  endproperty
  a_echo_loop: assert property (p_echo_loop) else $error("echo mismatch");

  property p_echo_arm;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in and s_echo_armed) |=> rsp_ff == RSP_ECHO && hold_ff && tx_ff == WORD_RST;
  endproperty
  a_echo_arm: assert property (p_echo_arm) else $error("echo not armed");

  property p_echo_once;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cs_rise && rsp_ff == RSP_ECHO |=> rsp_ff == RSP_NONE && tx_ff == WORD_RST;
  endproperty
  a_echo_once: assert property (p_echo_once) else $error("echo persisted");

  property p_diag_load;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cs_rise && full_ff && rsp_ff != RSP_ECHO && ctrl == CMD_DIAG_LO
      |=> tx_ff == $past(diag_word) && rsp_ff == RSP_DIAG && !hi_ff;
  endproperty
  a_diag_load: assert property (p_diag_load) else $error("bank 1 diag not loaded");

  property p_diag_hi;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cs_rise && full_ff && rsp_ff != RSP_ECHO && ctrl == CMD_DIAG_HI
      |=> rsp_ff == RSP_DIAG && hi_ff;
  endproperty
  a_diag_hi: assert property (p_diag_hi) else $error("bank 2 diag not loaded");

  property p_read_load;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cs_rise && full_ff && rsp_ff != RSP_ECHO
      && (ctrl == CMD_READ_LO || ctrl == CMD_READ_HI)
      |=> tx_ff == $past(read_word) && rsp_ff == RSP_READ;
  endproperty
  a_read_load: assert property (p_read_load) else $error("read-back not loaded");

  property p_first_bit;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cs_fall && rsp_ff != RSP_ECHO |=> so_ff == $past(tx_ff[15]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("msb not first");

  property p_clear;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && clr_lo && stat_code(fault_in[0]) == STAT_OK |=> diag_ff[0] == STAT_OK;
  endproperty
  a_clear: assert property (p_clear) else $error("bank not cleared");
endmodule

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model
(
  input  wire logic clk_in,   // core clock, paces sclk
  output      logic cs_n_out, // chip select, low active
  output      logic sclk_out, // serial clock, idle low
  output      logic si_out,   // data to device
  input  wire logic so_in     // data from device
);
  localparam int HALF = 20; // 80 ns at 4 ns clock
  // idle bus; sclk stands still outside frames
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // one frame msb first; nbits < 16 models a host that quits early
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    si_out   <= tx[15];
    repeat (HALF) @(posedge clk_in);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      sclk_out <= 1'b1;
      rx[i] = so_in;
      repeat (HALF) @(posedge clk_in);
      sclk_out <= 1'b0;
      si_out   <= (i > 0) ? tx[i-1] : ~tx[0];
      repeat (HALF) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    si_out   <= ~si_out; // released: never leave a stale level
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ==== tb/spi_diag_readout_tb.sv ====
`timescale 1ns/1ps
module spi_diag_readout_tb;
  import diag_readout_pkg::*;
  localparam int LIMIT = 40000; // about 60 frames
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               ce  = 1'b1;
  logic               cs_n, sclk, si, so, so_oe_n, hold;
  logic [15:0]        par    = 16'hA53C;
  chan_fault_s [15:0] faults = '0;
  int                 num_errors = 0;
  int                 n_checks   = 0;
  int                 cycles     = 0;
  // clock
  always #2 clk = ~clk;
  spi_diag_readout u_spi_diag_readout (.clk_in(clk), .rst_in(rst), .ce_in(ce),
    .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si), .par_in(par), .fault_in(faults),
    .so_out(so), .so_oe_n_out(so_oe_n), .outputs_hold_out(hold));
  spi_host_model u_spi_host_model (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk),
    .si_out(si), .so_in(so));
  ////////////////////////////////////////////////////////////////////
  // expected words, worked out from the live fault table
  function automatic logic [1:0] stat(int ch);
    if (faults[ch].short_gnd) return STAT_SHORT;
    if (faults[ch].open_load) return STAT_OPEN;
    if (faults[ch].ovld) return STAT_OVLD;
    return STAT_OK;
  endfunction
  function automatic logic [15:0] exp_rsp(logic [7:0] cmd);
    logic [15:0] w;
    int          base;
    logic        rd;
    w    = WORD_RST;
    base = cmd[0] ? 8 : 0;
    rd   = (cmd == CMD_READ_LO) || (cmd == CMD_READ_HI);
    for (int k = 0; k < 8; k++)
    begin
      if (!rd) w[2*k +: 2] = stat(base + k);
      else w[k] = (stat(base + k) == STAT_OK);
    end
    if (rd) w[15:8] = par[base +: 8];
    return w;
  endfunction
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fr(logic [15:0] tx, output logic [15:0] rx, input int n = 16);
    u_spi_host_model.xfer(tx, n, rx);
  endtask
  ////////////////////////////////////////////////////////////////////
  // every diag and read code, back to back, each judged one frame later
  task automatic t_diag_read();
    logic [7:0]         cmds [5];
    logic [15:0]        rx;
    chan_fault_s [15:0] f;
    cmds = '{CMD_DIAG_LO, CMD_DIAG_HI, CMD_READ_LO, CMD_READ_HI, CMD_DIAG_LO};
    f = '0;
    f[0].short_gnd = 1'b1;
    f[1].open_load = 1'b1;
    f[2].ovld = 1'b1;
    f[9].open_load = 1'b1;
    f[15] = 3'b110; // open load must win over overload
    @(posedge clk);
    faults <= f;
    fr({cmds[0], 8'hFF}, rx);
    for (int i = 1; i < 5; i++)
    begin
      fr({cmds[i], 8'h5A}, rx);
      check("response word", exp_rsp(cmds[i-1]), rx);
      check("outputs held", 16'h0001, {15'h0, hold});
      check("so released", 16'h0001, {15'h0, so_oe_n});
    end
    $display("test diag_read done");
  endtask
  // a fault seen once stays latched until its bank is read out
  task automatic t_clear();
    logic [15:0] rx;
    @(posedge clk);
    faults <= '0;
    fr({CMD_DIAG_LO, 8'h00}, rx);
    faults[4].ovld <= 1'b1;
    repeat (4) @(posedge clk);
    faults <= '0;
    fr(16'h0000, rx);
    check("sticky status", 16'hFFE4, rx);
    fr(16'h0000, rx);
    check("latched status", 16'hFEFF, rx);
    fr(16'h0000, rx);
    check("cleared status", 16'hFFFF, rx);
    $display("test clear done");
  endtask
  // both echo codes; the looped frame is not decoded, the next word is zero
  task automatic t_echo();
    logic [7:0]  codes [2];
    logic [15:0] rx;
    codes = '{CMD_ECHO_LO, CMD_ECHO_HI};
    for (int i = 0; i < 2; i++)
    begin
      fr({codes[i], 8'h3C}, rx);
      check("echo hold", 16'h0001, {15'h0, hold});
      fr(16'hC05A, rx);
      check("echo word", 16'hC05A, rx);
      fr(16'h0F00, rx);
      check("after echo", WORD_RST, rx);
    end
    $display("test echo done");
  endtask
  // unknown code and a short frame give a zero word and no hold
  task automatic t_refuse();
    logic [15:0] rx;
    fr(16'h7000, rx);
    check("unknown hold", 16'h0000, {15'h0, hold});
    fr({CMD_READ_LO, 8'h00}, rx, 8);
    check("unknown word", WORD_RST, rx);
    check("short hold", 16'h0000, {15'h0, hold});
    fr(16'h0000, rx);
    check("short word", WORD_RST, rx);
    $display("test refuse done");
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard: a stuck handshake ends the run as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("reset pins", 16'h0002, {13'h0, so, so_oe_n, hold});
    t_diag_read();
    t_clear();
    t_echo();
    t_refuse();
    stop_test();
  end
endmodule
